// file: fuc_pkg.sv
package fuc_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL   = 4'h0;
  localparam logic [3:0] OFF_AUX    = 4'h4;
  localparam logic [3:0] OFF_STATUS = 4'h8;
  localparam logic [3:0] OFF_MASK   = 4'hC;

  // ----------------------------------------------------------------
  // Control field layout
  // ----------------------------------------------------------------
  localparam int          CTL_W     = 17;
  localparam logic [16:0] CTL_RESET = 17'h00006;
  localparam logic [16:0] CTL_WMASK = 17'h19FFF;
  localparam int          B_SHORT   = 16;
  localparam int          B_WIDE    = 15;
  localparam int          B_SRCV    = 14;
  localparam int          B_SXMIT   = 13;
  localparam int          B_PRIV    = 12;
  localparam int          B_BPM_HI  = 11;
  localparam int          B_BPM_LO  = 10;
  localparam int          F_SBE     = 8;
  localparam int          W_SBE     = 2;
  localparam int          B_SDE_HI  = 7;
  localparam int          F_SPE     = 3;
  localparam int          W_SPE     = 3;
  localparam int          F_ICE     = 1;
  localparam int          W_ICE     = 2;
  localparam int          B_SYSTEM_COUNT_ENABLE    = 0;

  // ----------------------------------------------------------------
  // Auxiliary enables and event bits
  // ----------------------------------------------------------------
  localparam int          AUX_W     = 3;
  localparam int          A_PROCESS_COUNT_ENABLE    = 0;
  localparam int          A_C0      = 1;
  localparam int          A_C1      = 2;
  localparam int          EV_W      = 2;
  localparam int          EV_ACV    = 0;
  localparam int          EV_DMISS  = 1;

  // ----------------------------------------------------------------
  // Virtual address formats
  // ----------------------------------------------------------------
  localparam int          VA_FULL   = 64;
  localparam int          VA_WIDE   = 48;
  localparam int          VA_NARROW = 43;

endpackage

// file: fuc_ctrl.sv
// Overview of operation
// - Bit 16 selects the short layout of the formatted fetch address read.
// - Bit 15 selects 43-bit (clear) or 48-bit (set) virtual address format.
// - Wide format: violation when address differs from sign extension of low 48 bits.
// - Wide format routes translation double misses to the four-level entry.
// - Writing bit 13 drives the serial ROM clock pin; bit is write-only.
// - Bit 12 lets reserved privileged instructions run in kernel mode; resets zero.
// - Prediction mode upper bit forces not-taken; clear uses dynamic predictor.
// - Prediction mode lower bit forces local history; clear lets chooser decide.
// - Bits 9:8 give prefetch count after a cache miss; zero means demand only.
// - Shadow field upper bit swaps in shadow registers; lower bit does nothing.
// - Bits 5:3 act exactly as the memory unit's superpage enables.
// - Bits 2:1 enable each cache set separately; reset value is 3.
// - Clearing a set enable blocks fills only; contents stay valid.
// - Bit 0 enables system-wide counting for individually enabled counters.
// - Process context counting enable is the per-process alternative.
// - Counter runs when its enable and either system or process enable set.
//
// The address map and the Avalon-MM register port were left to the implementer.
module fuc_ctrl
(
  // Clock, reset, enable
  input  wire logic        CLOCK,
  input  wire logic        RST_N,
  input  wire logic        CE,
  // Avalon-MM slave
  input  wire logic [3:0]  ADDRESS,
  input  wire logic        READ,
  input  wire logic        WRITE,
  input  wire logic [31:0] WRITEDATA,
  input  wire logic [3:0]  BYTEENABLE,
  output logic      [31:0] READDATA,
  output logic             WAITREQUEST,
  // Address checker and translation miss
  input  wire logic        VA_CHECK_VALID,
  input  wire logic [63:0] VA_IN,
  input  wire logic        DOUBLE_MISS,
  output logic             ACCESS_VIOLATION,
  output logic             FOUR_LEVEL_DOUBLE_MISS_ENTRY,
  output logic             THREE_LEVEL_DOUBLE_MISS_ENTRY,
  // Serial ROM pins
  input  wire logic        SERIAL_ROM_RECEIVE,
  output logic             SERIAL_ROM_CLOCK_PIN,
  // Control field outputs
  output logic             FORMATTED_VA_SHORT_LAYOUT,
  output logic             WIDE_VADDR_SELECT,
  output logic             PRIVILEGED_INSN_ENABLE,
  output logic             PREDICT_NOT_TAKEN,
  output logic             PREDICT_LOCAL_ONLY,
  output logic      [1:0]  PREFETCH_STREAM_DEPTH,
  output logic             SHADOW_REGS_ENABLE,
  output logic      [2:0]  SUPERPAGE_ENABLE,
  output logic      [1:0]  ICACHE_FILL_ENABLE,
  output logic      [1:0]  COUNTER_RUN,
  // Interrupt
  output logic             IRQ
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [fuc_pkg::CTL_W-1:0] ctl;
    logic [fuc_pkg::AUX_W-1:0] aux;
    logic [fuc_pkg::EV_W-1:0]  status;
    logic [fuc_pkg::EV_W-1:0]  mask;
    logic                      srom_clk;
    logic [2:0]                sync;
    logic                      rcv;
    logic                      wait_q;
    logic [31:0]               rdata;
    logic                      access_violation;
    logic                      dm4;
    logic                      dm3;
    logic [1:0]                run;
    logic                      irq;
  } fuc_state_t;

  fuc_state_t s;
  fuc_state_t n;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

  // Sign-extension check for either address format
  function automatic logic va_bad(input logic [63:0] va, input logic wide);
    logic [63:0] s_wide;
    logic [63:0] s_narrow;
    s_wide   = {{(fuc_pkg::VA_FULL - fuc_pkg::VA_WIDE){va[fuc_pkg::VA_WIDE-1]}},
                va[fuc_pkg::VA_WIDE-1:0]};
    s_narrow = {{(fuc_pkg::VA_FULL - fuc_pkg::VA_NARROW){va[fuc_pkg::VA_NARROW-1]}},
                va[fuc_pkg::VA_NARROW-1:0]};
    return wide ? (va != s_wide) : (va != s_narrow);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic        req;
  logic [31:0] merged;
  logic [31:0] rd;

  assign req = READ || WRITE;

  always_comb
  begin
    n      = s;
    merged = 32'h0000_0000;
    rd     = 32'h0000_0000;
    if (!RST_N)
    begin
      n        = '0;
      n.ctl    = fuc_pkg::CTL_RESET;
      n.wait_q = 1'b1;
    end
    else if (CE)
    begin
      n.access_violation = 1'b0;
      n.dm4 = 1'b0;
      n.dm3 = 1'b0;
      // Serial receive pin: act once second and third stages agree
      n.sync = {s.sync[1:0], SERIAL_ROM_RECEIVE};
      if (s.sync[1] == s.sync[2])
        n.rcv = s.sync[2];

      // Answer one cycle after a request is seen; data captured early
      if (req && s.wait_q)
      begin
        n.wait_q = 1'b0;
        case (ADDRESS)
          fuc_pkg::OFF_CTRL:
          begin
            rd[fuc_pkg::CTL_W-1:0] = s.ctl;
            rd[fuc_pkg::B_SXMIT] = 1'b0;
            rd[fuc_pkg::B_SRCV]  = s.rcv;
          end
          fuc_pkg::OFF_AUX:    rd[fuc_pkg::AUX_W-1:0] = s.aux;
          fuc_pkg::OFF_STATUS: rd[fuc_pkg::EV_W-1:0]  = s.status;
          fuc_pkg::OFF_MASK:   rd[fuc_pkg::EV_W-1:0]  = s.mask;
          default:             rd = 32'h0000_0000;
        endcase
        n.rdata = rd;
      end
      else if (!s.wait_q)
      begin
        n.wait_q = 1'b1;
        if (WRITE)
        begin
          case (ADDRESS)
            fuc_pkg::OFF_CTRL:
            begin
              merged = be_merge({15'h0000, s.ctl}, WRITEDATA, BYTEENABLE);
              // format select among the written fields
              n.ctl = merged[fuc_pkg::CTL_W-1:0] & fuc_pkg::CTL_WMASK;
              // written value goes to the clock pin
              if (BYTEENABLE[1])
                n.srom_clk = WRITEDATA[fuc_pkg::B_SXMIT];
            end
            fuc_pkg::OFF_AUX:
            begin
              merged = be_merge({29'h0000_0000, s.aux}, WRITEDATA, BYTEENABLE);
              n.aux  = merged[fuc_pkg::AUX_W-1:0];
            end
            fuc_pkg::OFF_STATUS:
            begin
              if (BYTEENABLE[0])
                n.status = s.status & ~WRITEDATA[fuc_pkg::EV_W-1:0];
            end
            fuc_pkg::OFF_MASK:
            begin
              if (BYTEENABLE[0])
                n.mask = WRITEDATA[fuc_pkg::EV_W-1:0];
            end
            default: n.mask = s.mask;
          endcase
        end
      end

      if (VA_CHECK_VALID)
        n.access_violation = va_bad(VA_IN, s.ctl[fuc_pkg::B_WIDE]);
      if (DOUBLE_MISS)
      begin
        n.dm4 = s.ctl[fuc_pkg::B_WIDE];
        n.dm3 = !s.ctl[fuc_pkg::B_WIDE];
      end
      // Events set after the clear so a same-cycle event survives
      if (n.access_violation)
        n.status[fuc_pkg::EV_ACV] = 1'b1;
      if (DOUBLE_MISS)
        n.status[fuc_pkg::EV_DMISS] = 1'b1;

      n.run[0] = n.aux[fuc_pkg::A_C0] &&
                 (n.ctl[fuc_pkg::B_SYSTEM_COUNT_ENABLE] || n.aux[fuc_pkg::A_PROCESS_COUNT_ENABLE]);
      n.run[1] = n.aux[fuc_pkg::A_C1] &&
                 (n.ctl[fuc_pkg::B_SYSTEM_COUNT_ENABLE] || n.aux[fuc_pkg::A_PROCESS_COUNT_ENABLE]);
      n.irq    = |(n.status & n.mask);
    end
  end

  always_ff @(posedge CLOCK)
  begin
    s <= n;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign READDATA                      = s.rdata;
  assign WAITREQUEST                   = s.wait_q;
  assign ACCESS_VIOLATION              = s.access_violation;
  assign FOUR_LEVEL_DOUBLE_MISS_ENTRY  = s.dm4;
  assign THREE_LEVEL_DOUBLE_MISS_ENTRY = s.dm3;
  assign SERIAL_ROM_CLOCK_PIN          = s.srom_clk;
  assign FORMATTED_VA_SHORT_LAYOUT     = s.ctl[fuc_pkg::B_SHORT];
  assign WIDE_VADDR_SELECT             = s.ctl[fuc_pkg::B_WIDE];
  assign PRIVILEGED_INSN_ENABLE        = s.ctl[fuc_pkg::B_PRIV];
  assign PREDICT_NOT_TAKEN             = s.ctl[fuc_pkg::B_BPM_HI];
  assign PREDICT_LOCAL_ONLY            = s.ctl[fuc_pkg::B_BPM_LO];
  assign PREFETCH_STREAM_DEPTH         = s.ctl[fuc_pkg::F_SBE +: fuc_pkg::W_SBE];
  // only the upper shadow bit matters
  assign SHADOW_REGS_ENABLE            = s.ctl[fuc_pkg::B_SDE_HI];
  // same meaning as the memory unit field
  assign SUPERPAGE_ENABLE              = s.ctl[fuc_pkg::F_SPE +: fuc_pkg::W_SPE];
  // fill gating only, no invalidate path
  assign ICACHE_FILL_ENABLE            = s.ctl[fuc_pkg::F_ICE +: fuc_pkg::W_ICE];
  assign COUNTER_RUN                   = s.run;
  assign IRQ                           = s.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  AST_ACV_WIDE: assert property (
    (CE && VA_CHECK_VALID && WIDE_VADDR_SELECT &&
     VA_IN != {{16{VA_IN[47]}}, VA_IN[47:0]}) |=> ACCESS_VIOLATION)
    else $error("wide address violation missed");

  AST_ACV_NARROW: assert property (
    (CE && VA_CHECK_VALID && !WIDE_VADDR_SELECT) |=>
    (ACCESS_VIOLATION == ($past(VA_IN) != {{21{$past(VA_IN[42])}}, $past(VA_IN[42:0])})))
    else $error("narrow address check wrong");

  AST_DMISS: assert property (
    (CE && DOUBLE_MISS) |=>
    (FOUR_LEVEL_DOUBLE_MISS_ENTRY == $past(WIDE_VADDR_SELECT)) &&
    (THREE_LEVEL_DOUBLE_MISS_ENTRY != FOUR_LEVEL_DOUBLE_MISS_ENTRY))
    else $error("double miss vector wrong");

  AST_SROM: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == 4'h0 && BYTEENABLE[1]) |=>
    SERIAL_ROM_CLOCK_PIN == $past(WRITEDATA[13]))
    else $error("serial clock pin not driven");

  AST_BPM: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == 4'h0 && BYTEENABLE[1]) |=>
    PREDICT_NOT_TAKEN == $past(WRITEDATA[11]) && PREDICT_LOCAL_ONLY == $past(WRITEDATA[10]))
    else $error("prediction mode not updated");

  AST_CNT: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == 4'h4 && BYTEENABLE[0]) |=>
    COUNTER_RUN[0] == ($past(WRITEDATA[1]) &&
                       ($past(WRITEDATA[0]) || $past(s.ctl[0]))))
    else $error("counter gating wrong");

  AST_WAIT: assert property (
    (CE && (READ || WRITE) && WAITREQUEST) |=> !WAITREQUEST ##1 WAITREQUEST || !CE)
    else $error("bus answer timing wrong");

  AST_IRQ: assert property (
    (CE && $past(CE) && ACCESS_VIOLATION) |-> s.status[0] && (IRQ || !s.mask[0]))
    else $error("violation event not recorded");

  // ----------------------------------------------------------------
  // Field update, reset and event checks
  // ----------------------------------------------------------------
  AST_RST_VAL: assert property (disable iff (1'b0)
    !RST_N |=> (s.ctl == fuc_pkg::CTL_RESET) && WAITREQUEST && !IRQ)
    else $error("reset value wrong");

  AST_SHORT: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[2]) |=>
    FORMATTED_VA_SHORT_LAYOUT == $past(WRITEDATA[fuc_pkg::B_SHORT]))
    else $error("short layout bit not updated");

  AST_WIDE: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[1]) |=>
    WIDE_VADDR_SELECT == $past(WRITEDATA[fuc_pkg::B_WIDE]))
    else $error("format select not updated");

  AST_PRIV: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[1]) |=>
    PRIVILEGED_INSN_ENABLE == $past(WRITEDATA[fuc_pkg::B_PRIV]))
    else $error("privileged enable not updated");

  AST_DEPTH: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[1]) |=>
    PREFETCH_STREAM_DEPTH == $past(WRITEDATA[fuc_pkg::F_SBE +: fuc_pkg::W_SBE]))
    else $error("prefetch depth not updated");

  AST_SHADOW: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[0]) |=>
    SHADOW_REGS_ENABLE == $past(WRITEDATA[fuc_pkg::B_SDE_HI]))
    else $error("shadow enable not updated");

  AST_SPE: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[0]) |=>
    SUPERPAGE_ENABLE == $past(WRITEDATA[fuc_pkg::F_SPE +: fuc_pkg::W_SPE]))
    else $error("superpage enables not updated");

  AST_ICE: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL && BYTEENABLE[0]) |=>
    ICACHE_FILL_ENABLE == $past(WRITEDATA[fuc_pkg::F_ICE +: fuc_pkg::W_ICE]))
    else $error("set enables not updated");

  AST_ICE_HOLD: assert property (
    !(CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL) |=>
    $stable(ICACHE_FILL_ENABLE))
    else $error("set enables changed without a write");

  AST_CNT1: assert property (
    (CE && WRITE && !WAITREQUEST && ADDRESS == fuc_pkg::OFF_AUX && BYTEENABLE[0]) |=>
    COUNTER_RUN[1] == ($past(WRITEDATA[fuc_pkg::A_C1]) &&
                       ($past(WRITEDATA[fuc_pkg::A_PROCESS_COUNT_ENABLE]) || $past(s.ctl[fuc_pkg::B_SYSTEM_COUNT_ENABLE]))))
    else $error("counter one gating wrong");

  AST_XMIT_RD: assert property (
    (CE && READ && WAITREQUEST && ADDRESS == fuc_pkg::OFF_CTRL) |=>
    !READDATA[fuc_pkg::B_SXMIT])
    else $error("write-only bit visible on read");

  AST_DM_STATUS: assert property (
    (CE && DOUBLE_MISS) |=> s.status[fuc_pkg::EV_DMISS])
    else $error("double miss event not recorded");

  AST_DM_ONEHOT: assert property (
    !(FOUR_LEVEL_DOUBLE_MISS_ENTRY && THREE_LEVEL_DOUBLE_MISS_ENTRY))
    else $error("both double miss entries raised");

  AST_ACV_SRC: assert property (
    ($past(CE) && ACCESS_VIOLATION) |-> $past(VA_CHECK_VALID))
    else $error("violation without a check");

endmodule // fuc_ctrl

// file: fuc_ctrl_test.sv
module fuc_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock, rst_n, ce, read, write, va_valid, dmiss, srom_rx;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, rd;
  logic [63:0] va_in;
  logic        waitrequest, access_violation, four_lvl, three_lvl, srom_clk, irq;
  logic        short_lay, wide_sel, priv_en, not_taken, local_only, shadow;
  logic [1:0]  depth, ic, crun;
  logic [2:0]  sp;
  logic [14:0] field_outs;
  logic [16:0] pats [4];
  logic [63:0] vas [5];
  int          err_total;
  int          compares;

  assign field_outs = {short_lay, wide_sel, priv_en, not_taken, local_only, depth,
                       shadow, sp, ic, srom_clk};

  fuc_ctrl u_dut
  (
    .CLOCK(clock), .RST_N(rst_n), .CE(ce), .ADDRESS(address), .READ(read),
    .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(byteenable),
    .READDATA(readdata), .WAITREQUEST(waitrequest), .VA_CHECK_VALID(va_valid),
    .VA_IN(va_in), .DOUBLE_MISS(dmiss), .ACCESS_VIOLATION(access_violation),
    .FOUR_LEVEL_DOUBLE_MISS_ENTRY(four_lvl), .THREE_LEVEL_DOUBLE_MISS_ENTRY(three_lvl),
    .SERIAL_ROM_RECEIVE(srom_rx), .SERIAL_ROM_CLOCK_PIN(srom_clk),
    .FORMATTED_VA_SHORT_LAYOUT(short_lay), .WIDE_VADDR_SELECT(wide_sel),
    .PRIVILEGED_INSN_ENABLE(priv_en), .PREDICT_NOT_TAKEN(not_taken),
    .PREDICT_LOCAL_ONLY(local_only), .PREFETCH_STREAM_DEPTH(depth),
    .SHADOW_REGS_ENABLE(shadow), .SUPERPAGE_ENABLE(sp), .ICACHE_FILL_ENABLE(ic),
    .COUNTER_RUN(crun), .IRQ(irq)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge clock);
    address   <= a;
    write     <= wr;
    read      <= ~wr;
    writedata <= wd;
    for (n = 0; n < 16; n++)
    begin
      @(posedge clock);
      if (waitrequest === 1'b0)
        break;
    end
    if (n == 16)
    begin
      err_total++;
      close_out();
    end
    rd = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task automatic wr_ctl(input logic [16:0] v);
    bus(1'b1, fuc_pkg::OFF_CTRL, {15'h0, v});
  endtask

  function automatic logic [14:0] exp_outs(input logic [16:0] v);
    return {v[16], v[15], v[12], v[11], v[10], v[9:8], v[7], v[5:3], v[2:1], v[13]};
  endfunction

  function automatic logic viol(input logic [63:0] va, input logic wide);
    if (wide)
      return va !== {{16{va[47]}}, va[47:0]};
    return va !== {{21{va[42]}}, va[42:0]};
  endfunction

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial
  begin
    {rst_n, read, write, va_valid, dmiss, srom_rx} = 6'h00;
    ce = 1'b1;
    address = 4'h0;
    byteenable = 4'hF;
    writedata = 32'h0;
    va_in = 64'h0;
    err_total = 0;
    compares = 0;
    pats = '{17'h1FFFF, 17'h0AAAA, 17'h15555, 17'h00002};
    vas = '{64'h0000_0400_0000_0000, 64'hFFFF_8000_0000_0000, 64'h0000_7FFF_FFFF_FFFF,
            64'hFFFF_FFFF_FFFF_FFFF, 64'h0001_0000_0000_0000};
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    @(negedge clock);
    check(field_outs, exp_outs(fuc_pkg::CTL_RESET));
    check({waitrequest, irq, crun}, 4'h8);
    rd_chk(fuc_pkg::OFF_CTRL, {15'h0, fuc_pkg::CTL_RESET});
    rd_chk(fuc_pkg::OFF_AUX, 32'h0);
    rd_chk(fuc_pkg::OFF_STATUS, 32'h0);
    rd_chk(fuc_pkg::OFF_MASK, 32'h0);
    $display("test reset done");
    foreach (pats[i])
    begin
      wr_ctl(pats[i]);
      @(negedge clock);
      check(field_outs, exp_outs(pats[i]));
      rd_chk(fuc_pkg::OFF_CTRL, {15'h0, pats[i] & fuc_pkg::CTL_WMASK});
    end
    srom_rx <= 1'b1;
    repeat (6) @(posedge clock);
    rd_chk(fuc_pkg::OFF_CTRL, 32'h04002);
    srom_rx <= 1'b0;
    $display("test fields done");
    for (int i = 0; i < 16; i++)
    begin
      wr_ctl({15'h1, i[3]});
      bus(1'b1, fuc_pkg::OFF_AUX, {29'h0, i[2:0]});
      @(negedge clock);
      check(crun, {i[2], i[1]} & {2{i[3] | i[0]}});
    end
    rd_chk(fuc_pkg::OFF_AUX, 32'h7);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    rd_chk(4'h2, 32'h0);
    rd_chk(fuc_pkg::OFF_CTRL, 32'h00003);
    $display("test counters done");
    for (int w = 0; w < 2; w++)
    begin
      wr_ctl({1'b0, w[0], 15'h0002});
      foreach (vas[k])
      begin
        @(posedge clock);
        va_valid <= 1'b1;
        va_in    <= vas[k];
        @(posedge clock);
        va_valid <= 1'b0;
        @(negedge clock);
        check(access_violation, viol(vas[k], w[0]));
      end
      @(posedge clock);
      dmiss <= 1'b1;
      @(posedge clock);
      dmiss <= 1'b0;
      @(negedge clock);
      check({four_lvl, three_lvl}, w[0] ? 2'b10 : 2'b01);
    end
    $display("test address checks done");
    rd_chk(fuc_pkg::OFF_STATUS, 32'h3);
    check(irq, 1'b0);
    bus(1'b1, fuc_pkg::OFF_MASK, 32'h1);
    repeat (2) @(negedge clock);
    check(irq, 1'b1);
    bus(1'b1, fuc_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(negedge clock);
    check(irq, 1'b0);
    rd_chk(fuc_pkg::OFF_STATUS, 32'h2);
    bus(1'b1, fuc_pkg::OFF_MASK, 32'h3);
    repeat (2) @(negedge clock);
    check(irq, 1'b1);
    bus(1'b1, fuc_pkg::OFF_STATUS, 32'h2);
    repeat (2) @(negedge clock);
    check(irq, 1'b0);
    rd_chk(fuc_pkg::OFF_STATUS, 32'h0);
    $display("test interrupt done");
    close_out();
  end

endmodule // fuc_ctrl_test
